// >>> hdl/prs_readout_seq.sv
// Operation
// - matrix 2752 columns by 2004 rows addressed
// - columns dark, boundary, active, boundary, dark
// - rows dark, boundary, active, boundary, dark
// - unmirrored rows green-red then blue-green
// - both greens are distinct colour codes
// - default first emitted pixel column 16, row 54
// - progressive rows, horizontal then vertical blanking
// - read top dark rows unless manual, hidden
// - eight dark rows after row binning
// - row skip ignored in dark rows
// - no dark rows: slots become vertical blanking
// - active rows from start, size, skip, mirror
// - active rows overlapping dark rows marked invalid only while dark rows are read
// - left then right dark columns first
// - column skip ignored in dark columns
// - no dark columns: slots stay in blanking
// - active columns windowed; overlaps marked invalid only while dark columns are read
// - 80, 40, 20 dark columns after binning
// - frame flag over rows, low in vblank
// - line flag only with emitted pixels
// - shown dark rows extend frame flag
module prs_readout_seq
   import prs_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              link_clk,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic                   frame_active_flag,
   output logic                   line_active_flag,
   output prs_pix_type            pix_out
);

   function automatic logic [31:0] prs_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ---------------- register bus ----------------
   logic [31:0]       cfg_r [CFG_NUM];
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              aw_hold_r;
   logic              w_hold_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [1:0]        rresp_r;
   logic [31:0]       rdata_r;

   logic              wr_do;
   logic              wr_map;
   logic [2:0]        wr_idx;
   logic              ar_take;
   logic              rd_cfg;
   logic              rd_stat;
   logic [2:0]        rd_idx;
   logic [31:0]       rd_data;
   logic [31:0]       status_w;

   assign wr_do   = aw_hold_r & w_hold_r & ~bvalid_r;
   assign wr_idx  = awaddr_r[4:2];
   assign wr_map  = (awaddr_r[ADDR_W-1:5] == '0);
   assign ar_take = s_axi_arvalid & arready_r;
   assign rd_idx  = s_axi_araddr[4:2];
   assign rd_cfg  = (s_axi_araddr[ADDR_W-1:5] == '0);
   assign rd_stat = (s_axi_araddr[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]);
   assign rd_data = rd_stat ? status_w
                  : rd_cfg ? cfg_r[rd_idx] : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid & awready_r) begin
         aw_hold_r <= 1'b1;
         awready_r <= 1'b0;
         awaddr_r  <= s_axi_awaddr;
      end else if (bvalid_r & s_axi_bready) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
      end else if (s_axi_wvalid & wready_r) begin
         w_hold_r <= 1'b1;
         wready_r <= 1'b0;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (bvalid_r & s_axi_bready) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h00000000;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= (rd_cfg | rd_stat) ? RESP_OKAY : RESP_SLVERR;
         rdata_r   <= rd_data;
      end else if (rvalid_r & s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   for (genvar i = 0; i < CFG_NUM; i++) begin : g_cfg
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cfg_r[i] <= CFG_RST[i];
         end else if (wr_do && wr_map && wr_idx == 3'(i)) begin
            cfg_r[i] <= prs_merge(cfg_r[i], wdata_r, wstrb_r)
                        & CFG_MASK[i];
         end
      end
   end

   // ---------------- configuration fields ----------------
   logic        run;
   logic        show_dr;
   logic        manual_black_level;
   logic        show_dc;
   logic        row_wise_black_correction;
   logic        row_mirror;
   logic        col_mirror;
   logic [10:0] row_start;
   logic [10:0] row_size;
   logic [11:0] col_start;
   logic [11:0] col_size;
   logic [2:0]  row_skip;
   logic [1:0]  row_bin;
   logic [2:0]  col_skip;
   logic [1:0]  col_bin;
   logic [11:0] hblank;
   logic [10:0] vblank;

   assign run                = cfg_r[IDX_CTRL][CTRL_RUN];
   assign show_dr            = cfg_r[IDX_CTRL][CTRL_SHOW_DR];
   assign manual_black_level = cfg_r[IDX_CTRL][CTRL_MANUAL];
   assign show_dc            = cfg_r[IDX_CTRL][CTRL_SHOW_DC];
   assign row_wise_black_correction = cfg_r[IDX_CTRL][CTRL_ROW_CORR];
   assign row_mirror = cfg_r[IDX_CTRL][CTRL_RMIRROR];
   assign col_mirror = cfg_r[IDX_CTRL][CTRL_CMIRROR];
   assign row_start  = cfg_r[IDX_RSTART][10:0];
   assign row_size   = cfg_r[IDX_RSIZE][10:0];
   assign col_start  = cfg_r[IDX_CSTART][11:0];
   assign col_size   = cfg_r[IDX_CSIZE][11:0];
   assign row_skip   = cfg_r[IDX_BINSKP][ROW_SKIP_LSB +: 3];
   assign row_bin    = cfg_r[IDX_BINSKP][ROW_BIN_LSB +: 2];
   assign col_skip   = cfg_r[IDX_BINSKP][COL_SKIP_LSB +: 3];
   assign col_bin    = cfg_r[IDX_BINSKP][COL_BIN_LSB +: 2];
   assign hblank     = cfg_r[IDX_HBLANK][11:0];
   assign vblank     = cfg_r[IDX_VBLANK][10:0];

   // ---------------- link clock edge ----------------
   logic lclk_s1_r;
   logic lclk_s2_r;
   logic lclk_s3_r;
   logic step;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lclk_s1_r <= 1'b0;
         lclk_s2_r <= 1'b0;
         lclk_s3_r <= 1'b0;
      end else begin
         lclk_s1_r <= link_clk;
         lclk_s2_r <= lclk_s1_r;
         lclk_s3_r <= lclk_s2_r;
      end
   end
   assign step = lclk_s2_r & ~lclk_s3_r;

   // ---------------- sequencer ----------------
   prs_rowph_type rph_r;
   prs_colph_type cph_r;
   logic [2:0]    drow_idx_r;
   logic [6:0]    dcol_idx_r;
   logic [10:0]   row_off_r;
   logic [11:0]   col_off_r;
   logic [11:0]   hb_cnt_r;
   logic [10:0]   vb_cnt_r;
   logic [15:0]   frame_cnt_r;
   logic          fa_r;
   logic          la_r;
   prs_pix_type   pix_r;

   logic          dark_rows_rd;
   logic          dark_cols_rd;
   logic [1:0]    rsh;
   logic [1:0]    csh;
   logic [10:0]   drow_addr;
   logic [10:0]   drow_end;
   logic [10:0]   act_row;
   logic [10:0]   row_addr;
   logic [6:0]    dcol_last;
   logic [11:0]   dcol_raw;
   logic [11:0]   dcol_addr;
   logic [11:0]   act_col;
   logic [11:0]   col_addr;
   logic [11:0]   row_off_inc;
   logic [12:0]   col_off_inc;
   logic          row_end;
   logic          row_done;
   logic          col_done;
   logic          row_res;
   logic          col_res;
   logic          fa_w;
   logic          la_w;

   assign dark_rows_rd = show_dr | ~manual_black_level;
   assign dark_cols_rd = show_dc | row_wise_black_correction;
   assign rsh = (row_bin == 2'h3) ? 2'h2 : {1'b0, |row_bin};
   assign csh = (col_bin == 2'h3) ? 2'h2 : {1'b0, |col_bin};

   assign drow_addr = DARK_ROW_FIRST + ({8'h00, drow_idx_r} << rsh);
   assign drow_end  = DARK_ROW_FIRST + (DARK_ROW_OUT << rsh);
   assign act_row = row_mirror ? row_start + row_size - row_off_r
                               : row_start + row_off_r;
   assign row_addr = (rph_r == RP_DARK) ? drow_addr : act_row;

   assign dcol_last = (DARK_COL_OUT >> csh) - 7'h01;
   assign dcol_raw  = {5'h00, dcol_idx_r} << csh;
   assign dcol_addr = (dcol_raw < DARK_COL_LEFT) ? dcol_raw
                    : dcol_raw + DARK_COL_RBASE;
   assign act_col = col_mirror ? col_start + col_size - col_off_r
                               : col_start + col_off_r;
   assign col_addr = (cph_r == CP_DARK) ? dcol_addr : act_col;

   assign row_off_inc = {1'b0, row_off_r} + {9'h000, row_skip} + 12'h001;
   assign col_off_inc = {1'b0, col_off_r} + {10'h000, col_skip}
                      + 13'h0001;
   assign row_done = row_off_inc > {1'b0, row_size};
   assign col_done = col_off_inc > {1'b0, col_size};
   assign row_end  = (cph_r == CP_HBL) && (hb_cnt_r == hblank);

   assign row_res = (rph_r == RP_ACT) & dark_rows_rd
                  & (act_row >= DARK_ROW_FIRST) & (act_row < drow_end);
   assign col_res = (cph_r == CP_ACT) & dark_cols_rd
                  & ((act_col < DARK_COL_LEFT)
                   | ((act_col >= DARK_COL_RFIRST)
                    & (act_col <= DARK_COL_RLAST)));

   assign fa_w = run & ((rph_r == RP_ACT)
               | ((rph_r == RP_DARK) & show_dr));
   // line flag only on emitted pixels
   assign la_w = fa_w & ((cph_r == CP_ACT)
               | ((cph_r == CP_DARK) & show_dc));

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         cph_r      <= CP_DARK;
         dcol_idx_r <= 7'h00;
         col_off_r  <= 12'h000;
         hb_cnt_r   <= 12'h000;
      end else if (step) begin
         case (cph_r)
            CP_DARK: begin
               // slots kept even when not read
               if (dcol_idx_r == dcol_last) begin
                  cph_r     <= CP_ACT;
                  col_off_r <= 12'h000;
               end else begin
                  dcol_idx_r <= dcol_idx_r + 7'h01;
               end
            end
            CP_ACT: begin
               if (col_done) begin
                  cph_r    <= CP_HBL;
                  hb_cnt_r <= 12'h000;
               end else begin
                  col_off_r <= col_off_inc[11:0];
               end
            end
            default: begin
               if (row_end) begin
                  cph_r      <= CP_DARK;
                  dcol_idx_r <= 7'h00;
               end else begin
                  hb_cnt_r <= hb_cnt_r + 12'h001;
               end
            end
         endcase
      end
   end

   // row phase: dark, active, vertical blanking
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         rph_r      <= RP_DARK;
         drow_idx_r <= 3'h0;
         row_off_r  <= 11'h000;
         vb_cnt_r   <= 11'h000;
      end else if (step && row_end) begin
         case (rph_r)
            RP_DARK: begin
               // unread dark slots act as blanking
               if (drow_idx_r == 3'h7) begin
                  rph_r     <= RP_ACT;
                  row_off_r <= 11'h000;
               end else begin
                  drow_idx_r <= drow_idx_r + 3'h1;
               end
            end
            RP_ACT: begin
               if (row_done) begin
                  rph_r    <= RP_VBL;
                  vb_cnt_r <= 11'h000;
               end else begin
                  row_off_r <= row_off_inc[10:0];
               end
            end
            default: begin
               if (vb_cnt_r == vblank) begin
                  rph_r      <= RP_DARK;
                  drow_idx_r <= 3'h0;
               end else begin
                  vb_cnt_r <= vb_cnt_r + 11'h001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_cnt_r <= 16'h0000;
      end else if (step && row_end && rph_r == RP_VBL
                   && vb_cnt_r == vblank) begin
         frame_cnt_r <= frame_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fa_r  <= 1'b0;
         la_r  <= 1'b0;
         pix_r <= '0;
      end else if (step) begin
         fa_r          <= fa_w;
         la_r          <= la_w;
         pix_r.row     <= row_addr;
         pix_r.col     <= col_addr;
         pix_r.color   <= prs_color_type'({row_addr[0], col_addr[0]});
         pix_r.invalid <= row_res | col_res;
      end
   end

   assign status_w = {frame_cnt_r, 1'b0, rph_r, 2'h0, row_addr};

   assign s_axi_awready     = awready_r;
   assign s_axi_wready      = wready_r;
   assign s_axi_bvalid      = bvalid_r;
   assign s_axi_bresp       = bresp_r;
   assign s_axi_arready     = arready_r;
   assign s_axi_rvalid      = rvalid_r;
   assign s_axi_rresp       = rresp_r;
   assign s_axi_rdata       = rdata_r;
   assign frame_active_flag = fa_r;
   assign line_active_flag  = la_r;
   assign pix_out           = pix_r;

   // ---------------- checks ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_LINE_IN_FRAME:
      assert property (la_r |-> fa_r)
      else $error("line flag without frame flag");

   AST_VBL_LOW:
      assert property (step && run && rph_r == RP_VBL |=> !fa_r)
      else $error("frame flag high in vertical blanking");

   AST_NO_DARK_ROWS:
      assert property (step && rph_r == RP_DARK && !show_dr
                       && manual_black_level |=> !fa_r && !la_r)
      else $error("dark rows emitted while disabled");

   AST_DARK_SHOWN:
      assert property (step && run && rph_r == RP_DARK && show_dr
                       |=> fa_r)
      else $error("shown dark row lacks frame flag");

   AST_HIDDEN_DCOL:
      assert property (step && cph_r == CP_DARK && !show_dc |=> !la_r)
      else $error("hidden dark column drove line flag");

   AST_HBL_LOW:
      assert property (step && cph_r == CP_HBL |=> !la_r)
      else $error("line flag high in horizontal blanking");

   AST_COLOR:
      assert property (la_r |-> pix_r.color == (pix_r.row[0]
                       ? (pix_r.col[0] ? CLR_GREEN_B : CLR_B)
                       : (pix_r.col[0] ? CLR_R : CLR_GREEN_R)))
      else $error("colour code does not match address parity");

   AST_ROW_RANGE:
      assert property (la_r && !row_mirror |-> pix_r.row < 11'(ROW_TOTAL)
                       && pix_r.col < 12'(COL_TOTAL))
      else $error("pixel address outside the matrix");

   AST_DCOL_RES:
      assert property (step && cph_r == CP_ACT && dark_cols_rd
                       && act_col < DARK_COL_LEFT |=> pix_r.invalid)
      else $error("resampled dark column not marked invalid");

   AST_DROW_BIN:
      assert property (rph_r == RP_DARK |-> drow_addr < drow_end)
      else $error("dark row beyond binned sample set");

endmodule

// >>> hdl/prs_pkg.sv
package prs_pkg;

   // array geometry
   localparam int          ROW_TOTAL       = 2004;
   localparam int          COL_TOTAL       = 2752;
   localparam logic [10:0] DARK_ROW_FIRST  = 11'h010;
   localparam logic [10:0] DARK_ROW_OUT    = 11'h008;
   localparam logic [6:0]  DARK_COL_OUT    = 7'h50;
   localparam logic [11:0] DARK_COL_LEFT   = 12'h00A;
   localparam logic [11:0] DARK_COL_RBASE  = 12'hA30;
   localparam logic [11:0] DARK_COL_RFIRST = 12'hA3A;
   localparam logic [11:0] DARK_COL_RLAST  = 12'hA7F;

   // register map
   localparam int          CFG_NUM    = 8;
   localparam logic [2:0]  IDX_CTRL   = 3'h0;
   localparam logic [2:0]  IDX_RSTART = 3'h1;
   localparam logic [2:0]  IDX_RSIZE  = 3'h2;
   localparam logic [2:0]  IDX_CSTART = 3'h3;
   localparam logic [2:0]  IDX_CSIZE  = 3'h4;
   localparam logic [2:0]  IDX_BINSKP = 3'h5;
   localparam logic [2:0]  IDX_HBLANK = 3'h6;
   localparam logic [2:0]  IDX_VBLANK = 3'h7;
   localparam logic [7:0]  OFF_STATUS = 8'h20;

   localparam logic [31:0] CFG_RST [CFG_NUM] = '{
      32'h00000001, 32'h00000036, 32'h00000797, 32'h00000010,
      32'h00000A1F, 32'h00000000, 32'h000001C1, 32'h00000019};
   localparam logic [31:0] CFG_MASK [CFG_NUM] = '{
      32'h0000007F, 32'h000007FF, 32'h000007FF, 32'h00000FFF,
      32'h00000FFF, 32'h00003737, 32'h00000FFF, 32'h000007FF};

   // control bits
   localparam int CTRL_RUN      = 0;
   localparam int CTRL_SHOW_DR  = 1;
   localparam int CTRL_MANUAL   = 2;
   localparam int CTRL_SHOW_DC  = 3;
   localparam int CTRL_ROW_CORR = 4;
   localparam int CTRL_RMIRROR  = 5;
   localparam int CTRL_CMIRROR  = 6;
   // bin and skip fields
   localparam int ROW_SKIP_LSB  = 0;
   localparam int ROW_BIN_LSB   = 4;
   localparam int COL_SKIP_LSB  = 8;
   localparam int COL_BIN_LSB   = 12;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RP_DARK = 2'b00, RP_ACT = 2'b01, RP_VBL = 2'b10
   } prs_rowph_type;

   typedef enum logic [1:0] {
      CP_DARK = 2'b00, CP_ACT = 2'b01, CP_HBL = 2'b10
   } prs_colph_type;

   typedef enum logic [1:0] {
      CLR_GREEN_R = 2'b00, CLR_R = 2'b01, CLR_B = 2'b10, CLR_GREEN_B = 2'b11
   } prs_color_type;

   typedef struct packed {
      logic [10:0]   row;
      logic [11:0]   col;
      prs_color_type color;
      logic          invalid;
   } prs_pix_type;

endpackage

// >>> tb/prs_host_rx.sv
module prs_host_rx
   import prs_pkg::*;
(
   input  wire logic        link_clk,
   input  wire logic        clear,
   input  wire logic        frame_active_flag,
   input  wire logic        line_active_flag,
   input  wire prs_pix_type pix_out,
   output prs_pix_type      first_pix,
   output int               line_len,
   output int               line_cnt,
   output int               inval_cnt,
   output int               clr_err,
   output int               flag_err,
   output int               frames
);
   timeunit 1ns;
   timeprecision 100ps;
   int   cur_len;
   logic got;
   logic fa_q;
   logic la_q;
   prs_color_type exp_c;

   // falling link edge: outputs settled
   always @(negedge link_clk) begin
      if (clear) begin
         got = 1'b0;
         cur_len = 0;
         line_len = 0;
         line_cnt = 0;
         inval_cnt = 0;
         clr_err = 0;
         flag_err = 0;
         frames = 0;
      end else begin
         if (line_active_flag === 1'b1 && frame_active_flag !== 1'b1)
            flag_err++;
         if (frame_active_flag === 1'b1 && line_active_flag === 1'b1) begin
            if (!got)
               first_pix = pix_out;
            got = 1'b1;
            cur_len++;
            if (pix_out.invalid === 1'b1)
               inval_cnt++;
            exp_c = pix_out.row[0] ? (pix_out.col[0] ? CLR_GREEN_B : CLR_B)
                                   : (pix_out.col[0] ? CLR_R : CLR_GREEN_R);
            if (pix_out.color !== exp_c)
               clr_err++;
         end
         if (la_q === 1'b1 && line_active_flag !== 1'b1) begin
            line_len = cur_len;
            cur_len = 0;
            line_cnt++;
         end
         if (fa_q === 1'b1 && frame_active_flag !== 1'b1)
            frames++;
      end
      fa_q = frame_active_flag;
      la_q = line_active_flag;
   end
endmodule

// >>> tb/tb.sv
module tb;
   import prs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int NS = 7;
   localparam logic [7:0]  T_CTRL [NS] = '{8'h01, 8'h03, 8'h09,
                                           8'h09, 8'h19, 8'h15, 8'h61};
   localparam logic [15:0] T_BS [NS] = '{16'h0000, 16'h0001, 16'h0000,
                                         16'h1000, 16'h3100, 16'h0000,
                                         16'h0000};
   localparam int T_RS [NS]  = '{54, 22, 54, 54, 54, 54, 54};
   localparam int T_CS [NS]  = '{16, 16, 4, 16, 16, 16, 16};
   localparam int T_LEN [NS] = '{4, 4, 84, 44, 22, 4, 4};
   localparam int T_LN [NS]  = '{2, 9, 2, 2, 2, 2, 2};
   localparam int T_FR [NS]  = '{54, 16, 54, 54, 54, 54, 55};
   localparam int T_FC [NS]  = '{16, 16, 0, 0, 0, 16, 19};
   localparam int T_INV [NS] = '{0, 4, 8, 0, 0, 0, 0};
   logic        aclk, aresetn, link_clk, clear;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid, fa, la;
   logic [1:0]  bresp, rresp;
   prs_pix_type pix, first_pix;
   int          line_len, line_cnt, inval_cnt, clr_err, flag_err, frames;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cyc = 0;

   prs_readout_seq #(.ADDR_W(8)) u_prs_readout_seq (
      .aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .frame_active_flag(fa), .line_active_flag(la), .pix_out(pix));

   prs_host_rx u_prs_host_rx (
      .link_clk(link_clk), .clear(clear), .frame_active_flag(fa),
      .line_active_flag(la), .pix_out(pix), .first_pix(first_pix),
      .line_len(line_len), .line_cnt(line_cnt), .inval_cnt(inval_cnt),
      .clr_err(clr_err), .flag_err(flag_err), .frames(frames));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      link_clk = 1'b0;
      #3;
      forever #62.5 link_clk = ~link_clk;
   end

   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic run_case(input int k);
      logic [1:0] r;
      int         n;
      axi_wr(8'h00, 32'h00000000, r);
      clear <= 1'b1;
      axi_wr(8'h04, 32'(T_RS[k]), r);
      axi_wr(8'h08, 32'h00000001, r);
      axi_wr(8'h0C, 32'(T_CS[k]), r);
      axi_wr(8'h10, 32'h00000003, r);
      axi_wr(8'h14, 32'(T_BS[k]), r);
      axi_wr(8'h18, 32'h00000000, r);
      axi_wr(8'h1C, 32'h00000000, r);
      clear <= 1'b0;
      axi_wr(8'h00, 32'(T_CTRL[k]), r);
      n = 0;
      while (frames == 0 && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      chk_w(frames, 1, "frame end");
      chk_w(line_len, T_LEN[k], "line length");
      chk_w(line_cnt, T_LN[k], "lines");
      chk_w(32'(first_pix.row), T_FR[k], "first row");
      chk_w(32'(first_pix.col), T_FC[k], "first col");
      chk_w(inval_cnt, T_INV[k], "invalid");
      chk_w(clr_err, 0, "colour");
      chk_w(flag_err, 0, "flags");
   endtask

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         error_cnt++;
         $display("[FAIL] %0t run too long", $time);
         stop_test();
      end
   end

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      aresetn = 1'b0;
      clear = 1'b1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < CFG_NUM; i++) begin
         axi_rd(8'(4 * i), d, r);
         chk_w(d, CFG_RST[i], "reset value");
      end
      axi_rd(8'h24, d, r);
      chk_w(d, 32'h00000000, "unmapped data");
      chk_w(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
      axi_wr(8'h24, 32'hFFFFFFFF, r);
      chk_w(32'(r), 32'(RESP_SLVERR), "unmapped write resp");
      axi_wr(8'h14, 32'hFFFFFFFF, r);
      chk_w(32'(r), 32'(RESP_OKAY), "write resp");
      axi_rd(8'h14, d, r);
      chk_w(d, CFG_MASK[IDX_BINSKP], "masked field");
      for (int k = 0; k < NS; k++)
         run_case(k);
      stop_test();
   end
endmodule
